// ===== fcs_pkg.sv
// Purpose: shared constants and types for the flash command host
// Assumes: byte-wide asynchronous flash with a 17-bit address
// Notes: register offsets are byte addresses on the Avalon-MM slave
package fcs_pkg;
  // clock and bus-cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SETUP_NS = 20;
  localparam int T_STROBE_NS = 70;
  localparam int T_CMD_GAP_US = 50;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest gap rounds down
  localparam int CMD_GAP_CYC_DFLT = (T_CMD_GAP_US * 1000) / CLK_PERIOD_NS;

  typedef logic [16:0] fcs_addr_t;
  typedef logic [7:0] fcs_byte_t;

  // unlock addresses and command bytes
  localparam fcs_addr_t UNLOCK_ADDR_1 = 17'h00555;
  localparam fcs_addr_t UNLOCK_ADDR_2 = 17'h002AA;
  localparam fcs_addr_t ANY_ADDR = 17'h00000;
  localparam fcs_byte_t UNLOCK_DATA_1 = 8'hAA;
  localparam fcs_byte_t UNLOCK_DATA_2 = 8'h55;
  localparam fcs_byte_t CMD_AUTOSEL = 8'h90;
  localparam fcs_byte_t CMD_PROGRAM = 8'hA0;
  localparam fcs_byte_t CMD_ERASE_SETUP = 8'h80;
  localparam fcs_byte_t CMD_CHIP_ERASE = 8'h10;
  localparam fcs_byte_t CMD_SECTOR_ERASE = 8'h30;
  localparam fcs_byte_t CMD_SUSPEND = 8'hB0;
  localparam fcs_byte_t CMD_RESUME = 8'h30;
  localparam fcs_byte_t CMD_RESET = 8'hF0;

  // register map
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam logic [4:0] REG_RDATA = 5'h10;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_SUSP = 1;
  localparam int ST_AUTOSEL = 2;
  localparam int ST_REFUSED = 3;
  // reset values
  localparam fcs_addr_t RST_ADDR = 17'h00000;
  localparam fcs_byte_t RST_BYTE = 8'h00;

  // operations software can order
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_AUTOSEL, OP_PROGRAM, OP_CHIP_ERASE,
    OP_SECTOR_ERASE, OP_SECTOR_ADD, OP_SUSPEND, OP_RESUME
  } fcs_op_t;

  // one flash bus cycle
  typedef struct packed {
    logic wr;
    fcs_addr_t addr;
    fcs_byte_t data;
  } fcs_cyc_req_t;

  // flash pins driven by the host
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    fcs_addr_t addr;
    fcs_byte_t dq_o;
    logic dq_oe;
  } fcs_pins_t;
endpackage : fcs_pkg

// ===== fcs_cycle.sv
// Purpose: one asynchronous flash read or write bus cycle
// Assumes: dq_i is synchronous to clk
// Notes: address and data stay stable across the whole strobe
`timescale 1ns/1ps
module fcs_cycle #(
  parameter int SETUP_N = fcs_pkg::SETUP_CYC,
  parameter int STROBE_N = fcs_pkg::STROBE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input fcs_pkg::fcs_cyc_req_t req,
  input wire logic [7:0] dq_i,
  output fcs_pkg::fcs_pins_t pins,
  output logic done,
  output logic [7:0] rdata
);
  import fcs_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fcs_cyc_state_t;
  fcs_cyc_state_t state_reg;
  logic [7:0] cnt_reg;
  logic wr_reg;

  // phase sequencing and pin drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= C_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: RST_ADDR, dq_o: RST_BYTE, dq_oe: 1'b0};
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        C_IDLE: begin
          if (req_valid) begin
            wr_reg <= req.wr;
            pins.ce_n <= 1'b0;
            pins.addr <= req.addr;
            pins.dq_o <= req.data;
            pins.dq_oe <= req.wr;
            cnt_reg <= 8'(SETUP_N - 1);
            state_reg <= C_SETUP;
          end
        end
        C_SETUP: begin
          if (cnt_reg == 8'h00) begin
            pins.we_n <= ~wr_reg;
            pins.oe_n <= wr_reg;
            cnt_reg <= 8'(STROBE_N - 1);
            state_reg <= C_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        C_STROBE: begin
          if (cnt_reg == 8'h00) begin
            pins.we_n <= 1'b1; // data held past the rising strobe
            pins.oe_n <= 1'b1;
            state_reg <= C_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        C_HOLD: begin
          pins.ce_n <= 1'b1;
          pins.dq_oe <= 1'b0;
          done <= 1'b1;
          state_reg <= C_IDLE;
        end
      endcase
    end
  end

  // read data sampled at the end of the output strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= RST_BYTE;
    end else if (state_reg == C_STROBE && cnt_reg == 8'h00 && !wr_reg) begin
      rdata <= dq_i;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_write_strobe;
    (!pins.we_n && pins.dq_oe && !pins.ce_n && pins.oe_n) [*7];
  endsequence
  sequence seq_write_release;
    pins.we_n && pins.dq_oe ##1 done;
  endsequence
  AST_WRITE_SHAPE: assert property ($fell(pins.we_n) |-> seq_write_strobe ##0 1'b1 ##1 seq_write_release)
    else $error("write cycle strobe shape wrong");
  AST_READ_NO_DRIVE: assert property (!pins.oe_n |-> !pins.dq_oe && pins.we_n && !pins.ce_n)
    else $error("data driven during read strobe");
  AST_CYCLE_ENDS: assert property ((state_reg == C_IDLE && req_valid) |-> ##[3:20] done)
    else $error("bus cycle did not finish");
endmodule : fcs_cycle

// ===== fcs_host.sv
// Purpose: host controller issuing flash command sequences from software orders
// Assumes: flash data inputs synchronous to clk; Avalon-MM slave with waitrequest
// Notes: one order runs at a time; status polling is left to software via read orders
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
// Behaviour
// - host may program bytes while suspended
// - single reset write returns to array read
// - autoselect is two unlock writes and a command write, then read
// - erase is six writes, last selects kind
// - host keeps command cycle gap below 50 us
module fcs_host #(
  parameter int CMD_GAP_CYC = fcs_pkg::CMD_GAP_CYC_DFLT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output fcs_pkg::fcs_pins_t flash_pins,
  input wire logic [7:0] flash_dq_i
);
  import fcs_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} fcs_seq_state_t;

  // number of bus cycles in each order
  function automatic logic [2:0] op_len(fcs_op_t op);
    unique case (op)
      OP_AUTOSEL, OP_PROGRAM: op_len = 3'h4;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: op_len = 3'h6;
      default: op_len = 3'h1;
    endcase
  endfunction : op_len

  // bus cycle for one step of an order
  function automatic fcs_cyc_req_t step_req(fcs_op_t op, logic [2:0] step, fcs_addr_t ua, fcs_byte_t ud);
    step_req = '{wr: 1'b1, addr: UNLOCK_ADDR_1, data: UNLOCK_DATA_1};
    unique case (op)
      OP_READ: step_req = '{wr: 1'b0, addr: ua, data: RST_BYTE};
      OP_RESET: step_req = '{wr: 1'b1, addr: ANY_ADDR, data: CMD_RESET};
      OP_SECTOR_ADD: step_req = '{wr: 1'b1, addr: ua, data: CMD_SECTOR_ERASE};
      OP_SUSPEND: step_req = '{wr: 1'b1, addr: ANY_ADDR, data: CMD_SUSPEND};
      OP_RESUME: step_req = '{wr: 1'b1, addr: ANY_ADDR, data: CMD_RESUME};
      default: begin
        if (step == 3'h1 || step == 3'h4) begin
          step_req = '{wr: 1'b1, addr: UNLOCK_ADDR_2, data: UNLOCK_DATA_2};
        end else if (step == 3'h2) begin
          step_req.data = (op == OP_AUTOSEL) ? CMD_AUTOSEL : (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
        end else if (step == 3'h3 && op == OP_AUTOSEL) begin
          step_req = '{wr: 1'b0, addr: ua, data: RST_BYTE};
        end else if (step == 3'h3 && op == OP_PROGRAM) begin
          step_req = '{wr: 1'b1, addr: ua, data: ud};
        end else if (step == 3'h5) begin
          // chip erase stays at the unlock address, sector erase names the sector
          step_req.data = (op == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE;
          step_req.addr = (op == OP_CHIP_ERASE) ? UNLOCK_ADDR_1 : ua;
        end
      end
    endcase
  endfunction : step_req

  fcs_seq_state_t state_reg;
  fcs_op_t op_reg;
  logic [2:0] step_reg;
  fcs_addr_t uaddr_reg;
  fcs_byte_t udata_reg;
  fcs_byte_t rdata_reg;
  logic susp_reg;
  logic autosel_reg;
  logic refused_reg;
  logic req_valid_reg;
  fcs_cyc_req_t req_reg;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  logic bus_wr;
  logic ctrl_wr;
  logic op_ok;
  logic start;
  logic seq_end;

  // an access completes at the edge where waitrequest is seen low
  assign bus_wr = avs_write && !avs_waitrequest;
  assign ctrl_wr = bus_wr && avs_address == REG_CTRL;
  assign op_ok = avs_writedata[3:0] <= 4'(OP_RESUME);
  assign start = ctrl_wr && state_reg == S_IDLE && op_ok;
  assign seq_end = state_reg == S_WAIT && cyc_done && step_reg == op_len(op_reg) - 3'h1;

  // waitrequest drops for one cycle, answering each access at its second edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // read data registered at the first edge, standing at the accepting edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        REG_CTRL: avs_readdata <= {28'h0000000, op_reg};
        REG_ADDR: avs_readdata <= {15'h0000, uaddr_reg};
        REG_WDATA: avs_readdata <= {24'h000000, udata_reg};
        REG_STATUS: avs_readdata <= {28'h0000000, refused_reg, autosel_reg, susp_reg, state_reg != S_IDLE};
        REG_RDATA: avs_readdata <= {24'h000000, rdata_reg};
        default: avs_readdata <= 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // address and data holding registers for the next order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uaddr_reg <= RST_ADDR;
      udata_reg <= RST_BYTE;
    end else if (bus_wr && avs_address == REG_ADDR) begin
      uaddr_reg <= avs_writedata[16:0];
    end else if (bus_wr && avs_address == REG_WDATA) begin
      udata_reg <= avs_writedata[7:0];
    end
  end

  // sticky refusal of orders while busy or with an unknown code; set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refused_reg <= 1'b0;
    end else if (ctrl_wr && !start) begin
      refused_reg <= 1'b1;
    end else if (bus_wr && avs_address == REG_STATUS && avs_writedata[ST_REFUSED]) begin
      refused_reg <= 1'b0;
    end
  end

  // order sequencer: issue each bus cycle once the previous one is done,
  // passing through S_ISSUE between cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      op_reg <= OP_READ;
      step_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (start) begin
            op_reg <= fcs_op_t'(avs_writedata[3:0]);
            step_reg <= 3'h0;
            state_reg <= S_ISSUE;
          end
        end
        S_ISSUE: state_reg <= S_WAIT;
        S_WAIT: begin
          if (seq_end) begin
            state_reg <= S_IDLE;
          end else if (cyc_done) begin
            step_reg <= step_reg + 3'h1;
            state_reg <= S_ISSUE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_valid_reg <= 1'b0;
      req_reg <= '{wr: 1'b0, addr: RST_ADDR, data: RST_BYTE};
    end else begin
      req_valid_reg <= state_reg == S_ISSUE;
      req_reg <= step_req(op_reg, step_reg, uaddr_reg, udata_reg);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      susp_reg <= 1'b0;
      autosel_reg <= 1'b0;
    end else if (seq_end) begin
      if (op_reg == OP_SUSPEND) begin
        susp_reg <= 1'b1;
      end else if (op_reg == OP_RESUME) begin
        susp_reg <= 1'b0;
      end
      if (op_reg == OP_AUTOSEL) begin
        autosel_reg <= 1'b1;
      end else if (op_reg == OP_RESET) begin
        autosel_reg <= 1'b0;
      end
    end
  end

  // last byte read from the flash (array, status or identification)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= RST_BYTE;
    end else if (seq_end && (op_reg == OP_READ || op_reg == OP_AUTOSEL)) begin
      rdata_reg <= cyc_rdata;
    end
  end

  fcs_cycle #(
    .SETUP_N(SETUP_CYC),
    .STROBE_N(STROBE_CYC)
  ) u_cycle (
    .clk(clk),
    .rst(rst),
    .req_valid(req_valid_reg),
    .req(req_reg),
    .dq_i(flash_dq_i),
    .pins(flash_pins),
    .done(cyc_done),
    .rdata(cyc_rdata)
  );

  // cycles since the current bus cycle was issued; a stuck cycle stretches the command gap
  logic [15:0] gap_cnt_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_cnt_reg <= 16'h0000;
    end else if (req_valid_reg || state_reg == S_IDLE) begin
      gap_cnt_reg <= 16'h0000;
    end else begin
      gap_cnt_reg <= gap_cnt_reg + 16'h0001;
    end
  end

  localparam int SEQ_BOUND = 40;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_GAP_LIMIT: assert property (gap_cnt_reg < 16'(CMD_GAP_CYC))
    else $error("command cycle gap too long");
  AST_UNLOCK_FIRST: assert property ((req_valid_reg && step_reg == 3'h0 && op_len(op_reg) != 3'h1)
    |-> req_reg.wr && req_reg.addr == UNLOCK_ADDR_1 && req_reg.data == UNLOCK_DATA_1)
    else $error("sequence does not open with first unlock");
  AST_AUTOSEL_READ: assert property ((req_valid_reg && op_reg == OP_AUTOSEL && step_reg == 3'h3)
    |-> !req_reg.wr && req_reg.addr == uaddr_reg)
    else $error("autoselect fourth cycle not a read");
  AST_ERASE_LAST: assert property ((req_valid_reg && step_reg == 3'h5)
    |-> req_reg.wr && (op_reg == OP_CHIP_ERASE ? req_reg.data == CMD_CHIP_ERASE && req_reg.addr == UNLOCK_ADDR_1
                       : req_reg.data == CMD_SECTOR_ERASE && req_reg.addr == uaddr_reg))
    else $error("erase sixth cycle wrong");
  AST_PROGRAM_DATA: assert property ((req_valid_reg && op_reg == OP_PROGRAM && step_reg == 3'h3)
    |-> req_reg.wr && req_reg.data == udata_reg && req_reg.addr == uaddr_reg)
    else $error("program target cycle wrong");
  sequence seq_reset_write;
    req_valid_reg && op_reg == OP_RESET && req_reg.wr && req_reg.data == CMD_RESET;
  endsequence
  AST_RESET_SINGLE: assert property ((req_valid_reg && op_reg == OP_RESET)
    |-> seq_reset_write ##[1:SEQ_BOUND] (state_reg == S_IDLE && !autosel_reg))
    else $error("reset order not a single F0 write");
endmodule : fcs_host

// ===== fcs_flash_model.sv
// Purpose: behavioural flash device answering the host pins
// Assumes: strobes move on clock edges, so sampling them on clk is exact
// Notes: times scaled to clock cycles; an undriven bus toggles every cycle
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter int WIN_CYC = 200,
  parameter int ERASE_CYC = 400,
  parameter int SUSP_CYC = 10,
  parameter int PROG_CYC = 8,
  parameter logic [7:0] MAKER_ID = 8'h1C, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h2D, // arbitrary value
  parameter logic [7:0] CONT_ID = 8'h3E, // arbitrary value
  parameter logic [3:0] PROT = 4'h2
) (
  input wire logic clk,
  input fcs_pkg::fcs_pins_t pins,
  output logic [7:0] dq
);
  import fcs_pkg::*;
  typedef enum logic [2:0] {S_RD, S_AUTO, S_PROG, S_WIN, S_ERASE, S_SUSP, S_CHIP} fcs_mst_t;
  fcs_mst_t st = S_RD;
  fcs_mst_t base = S_RD;
  logic [7:0] mem [0:131071];
  logic [3:0] sel = 4'h0;
  logic [16:0] a_lat = 17'h00000;
  logic [7:0] program_byte = 8'h00;
  logic [7:0] dq_r = 8'h00;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  logic tg1 = 1'b0;
  logic tg2 = 1'b0;
  int step = 0;
  int tmr = 0;
  int etmr = 0;
  int stop = 0;

  // erased array at start
  initial foreach (mem[i]) mem[i] = 8'hFF;
  assign dq = dq_r;

  // answer of one read cycle
  function automatic logic [7:0] rv(input logic [16:0] a);
    case (st)
      S_AUTO: return a[7:0] == 8'h00 ? MAKER_ID : a[7:0] == 8'h01 ? PART_ID :
        a[7:0] == 8'h03 ? CONT_ID : {7'h00, PROT[a[16:15]]};
      S_PROG: return {~program_byte[7], tg1, 6'h00};
      S_SUSP: return sel[a[16:15]] ? {5'h10, tg2, 2'b00} : mem[a];
      S_RD: return mem[a];
      default: return {1'b0, tg1, 2'b00, st != S_WIN, tg2, 2'b00};
    endcase
  endfunction : rv

  // unlock and command pattern decoder
  task automatic seq(input logic [16:0] a, input logic [7:0] d, input logic hit);
    case (step)
      0: step = (hit && d == UNLOCK_DATA_1) ? 1 : 0;
      1: step = (a[10:0] == 11'h2AA && d == UNLOCK_DATA_2) ? 2 : 0;
      2: begin
        if (hit && d == CMD_AUTOSEL) begin
          base = st;
          st = S_AUTO;
        end
        step = (hit && d == CMD_PROGRAM) ? 7 : (hit && d == CMD_ERASE_SETUP && st == S_RD) ? 3 : 0;
      end
      3: step = (hit && d == UNLOCK_DATA_1) ? 4 : 0;
      4: step = (a[10:0] == 11'h2AA && d == UNLOCK_DATA_2) ? 5 : 0;
      5: begin
        sel = (hit && d == CMD_CHIP_ERASE) ? 4'hF : 4'h0;
        if (d == CMD_SECTOR_ERASE) sel[a[16:15]] = 1'b1;
        st = sel == 4'hF ? S_CHIP : sel != 4'h0 ? S_WIN : S_RD;
        etmr = sel == 4'hF ? ERASE_CYC : WIN_CYC;
        step = 0;
      end
      default: begin
        // program then back to old mode
        base = st;
        mem[a] = mem[a] & d;
        program_byte = d;
        st = S_PROG;
        tmr = PROG_CYC;
        step = 0;
      end
    endcase
  endtask : seq

  // one completed write cycle
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    case (st)
      S_WIN: begin
        if (d == CMD_SUSPEND) begin
          st = S_SUSP;
          etmr = ERASE_CYC;
        end else if (d == CMD_SECTOR_ERASE) begin
          sel[a[16:15]] = 1'b1;
          etmr = WIN_CYC;
        end else begin
          st = S_RD;
        end
      end
      S_ERASE: if (d == CMD_SUSPEND && stop == 0) stop = SUSP_CYC;
      S_AUTO: if (d == CMD_RESET) st = base;
      S_SUSP, S_RD: begin
        if (st == S_SUSP && step == 0 && d == CMD_RESUME) st = S_ERASE;
        else seq(a, d, a[10:0] == 11'h555);
      end
      default: ;
    endcase
  endtask : wr

  // timers, strobes and read data, sampled on the clock
  always @(posedge clk) begin
    if (tmr > 0) tmr = tmr - 1;
    else if (st == S_PROG) st = base;
    if (stop == 1 && st == S_ERASE) st = S_SUSP;
    if (stop > 0) stop = stop - 1;
    if (etmr > 0 && (st == S_WIN || st == S_ERASE || st == S_CHIP)) begin
      etmr = etmr - 1;
    end else if (st == S_WIN) begin
      st = S_ERASE;
      etmr = ERASE_CYC;
    end else if (st == S_ERASE || st == S_CHIP) begin
      foreach (mem[i]) if (sel[i / 32768]) mem[i] = 8'hFF;
      sel = 4'h0;
      st = S_RD;
    end
    if (!pins.ce_n && !pins.we_n && we_q) a_lat = pins.addr;
    if (!pins.ce_n && pins.we_n && !we_q) wr(a_lat, pins.dq_o);
    we_q = pins.we_n;
    if (!pins.ce_n && !pins.oe_n) begin
      if (oe_q) begin
        tg1 = ~tg1;
        tg2 = tg2 ^ sel[pins.addr[16:15]];
      end
      dq_r <= rv(pins.addr);
    end else begin
      dq_r <= ~dq_r; // released bus never holds its value
    end
    oe_q = pins.oe_n;
  end
endmodule : fcs_flash_model

// ===== tb_top.sv
// Purpose: self-checking bench for the flash command host
// Assumes: flash model on the pins, times scaled to cycles
// Notes: plain orders run from a table, suspend cases by hand
`timescale 1ns/1ps
module tb_top;
  import fcs_pkg::*;
  localparam logic [7:0] MAKER_ID = 8'h1C; // arbitrary value
  localparam logic [7:0] PART_ID = 8'h2D; // arbitrary value
  localparam logic [7:0] CONT_ID = 8'h3E; // arbitrary value
  typedef struct {
    fcs_op_t op;
    fcs_addr_t a;
    fcs_byte_t d;
    logic rd;
    fcs_byte_t exp;
  } fcs_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  fcs_pins_t flash_pins;
  logic [7:0] flash_dq_i;
  int bad_count = 0;
  int samples_checked = 0;
  fcs_byte_t b0;
  fcs_byte_t b1;
  logic [31:0] q;
  fcs_row_t rows [12] = '{
    '{OP_READ, 17'h00010, 8'h00, 1'b1, 8'hFF},
    '{OP_PROGRAM, 17'h00010, 8'h5A, 1'b0, 8'h00},
    '{OP_READ, 17'h00010, 8'h00, 1'b1, 8'h5A},
    '{OP_AUTOSEL, 17'h00000, 8'h00, 1'b1, MAKER_ID},
    '{OP_AUTOSEL, 17'h00001, 8'h00, 1'b1, PART_ID},
    '{OP_AUTOSEL, 17'h00003, 8'h00, 1'b1, CONT_ID},
    '{OP_AUTOSEL, 17'h08002, 8'h00, 1'b1, 8'h01},
    '{OP_AUTOSEL, 17'h10002, 8'h00, 1'b1, 8'h00},
    '{OP_RESET, 17'h00000, 8'h00, 1'b0, 8'h00},
    '{OP_RESUME, 17'h00000, 8'h00, 1'b0, 8'h00},
    '{OP_SUSPEND, 17'h00000, 8'h00, 1'b0, 8'h00},
    '{OP_READ, 17'h00010, 8'h00, 1'b1, 8'h5A}
  };

  // clock
  always #5 clk = ~clk;

  fcs_host #(.CMD_GAP_CYC(100)) DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_pins(flash_pins), .flash_dq_i(flash_dq_i));
  fcs_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID), .CONT_ID(CONT_ID)) FLASH (.clk(clk),
    .pins(flash_pins), .dq(flash_dq_i));

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one Avalon access, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rq);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) bad_count++;
    if (n >= 50) test_done();
  endtask : av

  // one order, then wait until the host is idle
  task automatic order(input fcs_op_t op, input fcs_addr_t a, input fcs_byte_t d);
    logic [31:0] r;
    int n;
    av(1'b1, REG_ADDR, {15'h0, a}, r);
    av(1'b1, REG_WDATA, {24'h0, d}, r);
    av(1'b1, REG_CTRL, {28'h0, op}, r);
    r = 32'h1;
    n = 0;
    while (r[ST_BUSY] !== 1'b0 && n < 200) begin
      av(1'b0, REG_STATUS, 32'h0, r);
      n++;
    end
    if (n >= 200) bad_count++;
    if (n >= 200) test_done();
  endtask : order

  // read one flash byte
  task automatic rd(input fcs_addr_t a, output fcs_byte_t b);
    logic [31:0] r;
    order(OP_READ, a, 8'h00);
    av(1'b0, REG_RDATA, 32'h0, r);
    b = r[7:0];
  endtask : rd

  // poll a byte until it reaches a value or the bound runs out
  task automatic until_byte(input fcs_addr_t a, input fcs_byte_t e, output fcs_byte_t b);
    int n;
    b = ~e;
    n = 0;
    while (b !== e && n < 100) begin
      rd(a, b);
      n++;
    end
  endtask : until_byte

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    test_done();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      order(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].rd) begin
        av(1'b0, REG_RDATA, 32'h0, q);
        chk(q[7:0], rows[i].exp);
      end
    end
    // sectors 2 and 3 erased, suspended inside the add window
    order(OP_SECTOR_ERASE, 17'h10000, 8'h00);
    order(OP_SECTOR_ADD, 17'h18000, 8'h00);
    order(OP_SUSPEND, 17'h00000, 8'h00);
    rd(17'h10000, b0);
    rd(17'h18004, b1);
    chk(b0[7], 1'b1);
    chk(b1[7], 1'b1);
    chk(b0[2] ^ b1[2], 1'b1);
    chk(b0[6] ^ b1[6], 1'b0);
    rd(17'h00010, b0);
    chk(b0, 8'h5A);
    order(OP_PROGRAM, 17'h00020, 8'h33);
    rd(17'h00020, b0);
    chk(b0, 8'h33);
    order(OP_AUTOSEL, 17'h10000, 8'h00);
    av(1'b0, REG_RDATA, 32'h0, q);
    chk(q[7:0], MAKER_ID);
    av(1'b0, REG_STATUS, 32'h0, q);
    chk(q[ST_AUTOSEL:ST_SUSP], 2'h3);
    order(OP_RESET, 17'h00000, 8'h00);
    rd(17'h10000, b0);
    chk(b0[7], 1'b1);
    order(OP_RESUME, 17'h00000, 8'h00);
    rd(17'h10000, b0);
    chk(b0[7], 1'b0);
    order(OP_RESUME, 17'h00000, 8'h00);
    rd(17'h10000, b0);
    chk(b0[7], 1'b0);
    order(OP_SUSPEND, 17'h00000, 8'h00);
    rd(17'h10000, b0);
    chk(b0[7], 1'b1);
    order(OP_RESUME, 17'h00000, 8'h00);
    until_byte(17'h10000, 8'hFF, b0);
    chk(b0, 8'hFF);
    // chip erase ignores a suspend
    order(OP_CHIP_ERASE, 17'h00000, 8'h00);
    order(OP_SUSPEND, 17'h00000, 8'h00);
    rd(17'h00020, b0);
    chk(b0[7], 1'b0);
    until_byte(17'h00020, 8'hFF, b0);
    chk(b0, 8'hFF);
    // refused order, sticky flag cleared by writing one, unmapped place
    av(1'b1, REG_CTRL, 32'h9, q);
    av(1'b0, REG_STATUS, 32'h0, q);
    chk(q[ST_REFUSED], 1'b1);
    av(1'b1, REG_STATUS, 32'h8, q);
    av(1'b0, REG_STATUS, 32'h0, q);
    chk(q[ST_REFUSED], 1'b0);
    av(1'b0, 5'h14, 32'h0, q);
    chk(q, 32'h0);
    // refused order leaves the last order and its address in place
    av(1'b0, REG_CTRL, 32'h0, q);
    chk(q, {28'h0, OP_READ});
    av(1'b0, REG_ADDR, 32'h0, q);
    chk(q, 32'h00000020);
    // reset in the middle of a bus cycle
    av(1'b1, REG_CTRL, {28'h0, OP_PROGRAM}, q);
    repeat (6) @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk({flash_pins, avs_waitrequest}, {1'b1, 1'b1, 1'b1, 17'h0, 8'h0, 1'b0, 1'b1});
    @(posedge clk);
    rst <= 1'b0;
    av(1'b0, REG_STATUS, 32'h0, q);
    chk(q[ST_BUSY], 1'b0);
    test_done();
  end
endmodule : tb_top
